/* pkg/scp_map.svh */
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH

// frame layout
`define SCP_HDR_BITS 4'd15
`define SCP_DATA_BITS 4'd7
`define SCP_RW_POS 15
`define SCP_ZERO_HI 14
`define SCP_ZERO_LO 12

// register addresses
`define SCP_A_PDN 12'h0C0
`define SCP_A_BLK 12'h0C1
`define SCP_A_CFG 12'h0C2
`define SCP_A_SCR 12'h0C3
`define SCP_A_STAT 12'h0C4
`define SCP_A_WIN 10'h030

// power control register fields
`define SCP_PDN_GLOBAL 0
`define SCP_PDN_REFMASK 1

// block power-down register fields
`define SCP_BLK_ADC_A 0
`define SCP_BLK_ADC_B 1
`define SCP_BLK_REF_GAIN 2
`define SCP_BLK_INT_REF 3
`define SCP_BLK_CLK_BUF 4
`define SCP_BLK_OUT_DRV 5
`define SCP_BLK_DECIM 6

// configuration register fields
`define SCP_CFG_IN_SE 0
`define SCP_CFG_CLK_SE 1
`define SCP_CFG_REF_INT 2
`define SCP_CFG_DDC_EN 3
`define SCP_CFG_IF_LO 4
`define SCP_CFG_IF_HI 5
`define SCP_CFG_OFFS_BIN 6

// reset values: all zero is the documented power-up default
`define SCP_RST_BYTE 8'h00

`endif

/* pkg/scp_pkg.sv */
package scp_pkg;

   typedef enum logic [1:0] {
      SCP_PH_HDR = 2'b01,
      SCP_PH_DATA = 2'b10
   } scp_phase_t;

   typedef enum logic [3:0] {
      SCP_REF_EXT = 4'b0001,
      SCP_REF_BUF = 4'b0010,
      SCP_REF_INT = 4'b0100,
      SCP_REF_INT_SE = 4'b1000
   } scp_ref_t;

endpackage

/* design/scp_sync.sv */
`timescale 1ns/1ps
module scp_sync #(
   parameter int W = 1
) (
   // clock
   input wire logic clk,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk) begin
            meta_q[i] <= d[i];
            sync_q[i] <= meta_q[i];
         end
      end
   endgenerate

   assign q = sync_q;

endmodule

/* design/scp_link.sv */
`timescale 1ns/1ps
`include "scp_map.svh"
module scp_link
   import scp_pkg::*;
(
   // serial link
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   // towards the system side
   input wire logic link_rst,
   input wire logic [7:0] status_in,
   output logic wr_toggle,
   output logic [11:0] wr_addr,
   output logic [7:0] wr_data
);

   scp_phase_t phase_q, phase_d;
   logic [3:0] bit_q, bit_d;
   logic [15:0] sh_q, sh_d;
   logic [15:0] hdr_q, hdr_d;
   logic tog_q, tog_d;
   logic [11:0] addr_q, addr_d;
   logic [7:0] data_q, data_d;
   logic [7:0] mir_q [0:3];
   logic [7:0] mir_d [0:3];
   logic sdo_q, sdo_d;
   logic oe_q, oe_d;
   logic [7:0] status_s;
   logic [7:0] rd_byte;
   logic [7:0] byte_in;
   logic commit;

   scp_sync #(.W(8)) u_stat_sync (
      .clk(sclk),
      .d(status_in),
      .q(status_s)
   );

   // frame shifter, cleared while chip select is high
   always_comb begin
      phase_d = phase_q;
      bit_d = bit_q + 4'd1;
      sh_d = {sh_q[14:0], sdio_in};
      hdr_d = hdr_q;
      commit = 1'b0;
      byte_in = {sh_q[6:0], sdio_in};
      case (phase_q)
         SCP_PH_HDR: begin
            if (bit_q == `SCP_HDR_BITS) begin
               phase_d = SCP_PH_DATA;
               bit_d = 4'd0;
               hdr_d = {sh_q[14:0], sdio_in};
            end
         end
         SCP_PH_DATA: begin
            // 24th edge: commit a write with bits 14:12 zero, then the next word starts afresh
            if (bit_q == `SCP_DATA_BITS) begin
               phase_d = SCP_PH_HDR;
               bit_d = 4'd0;
               commit = !hdr_q[`SCP_RW_POS] &&
                        (hdr_q[`SCP_ZERO_HI:`SCP_ZERO_LO] == 3'd0);
            end
         end
         default: begin
            phase_d = SCP_PH_HDR;
            bit_d = 4'd0;
         end
      endcase
   end

   // partial words die here, with no write ever issued; srst clears it too, so a
   // controller that holds chip select low from power-up never leaves it unknown
   always_ff @(posedge sclk or posedge chip_select_n or posedge link_rst) begin
      if (chip_select_n || link_rst) begin
         phase_q <= SCP_PH_HDR;
         bit_q <= 4'd0;
         sh_q <= 16'h0000;
         hdr_q <= 16'h0000;
      end else begin
         phase_q <= phase_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         hdr_q <= hdr_d;
      end
   end

   // write port: mirror for readback plus held word for the system side
   always_comb begin
      tog_d = tog_q;
      addr_d = addr_q;
      data_d = data_q;
      for (int k = 0; k < 4; k++) begin
         mir_d[k] = mir_q[k];
      end
      if (commit) begin
         tog_d = ~tog_q;
         addr_d = hdr_q[11:0];
         data_d = byte_in;
         if (hdr_q[11:2] == `SCP_A_WIN) begin
            mir_d[hdr_q[1:0]] = byte_in;
         end
      end
   end

   always_ff @(posedge sclk or posedge link_rst) begin
      if (link_rst) begin
         tog_q <= 1'b0;
         addr_q <= 12'h000;
         data_q <= `SCP_RST_BYTE;
         for (int k = 0; k < 4; k++) begin
            mir_q[k] <= `SCP_RST_BYTE;
         end
      end else begin
         tog_q <= tog_d;
         addr_q <= addr_d;
         data_q <= data_d;
         for (int k = 0; k < 4; k++) begin
            mir_q[k] <= mir_d[k];
         end
      end
   end

   // readback: launched on falling edges so the controller sees it settled
   always_comb begin
      rd_byte = 8'h00;
      if (hdr_q[11:2] == `SCP_A_WIN) begin
         rd_byte = mir_q[hdr_q[1:0]];
      end else if (hdr_q[11:0] == `SCP_A_STAT) begin
         rd_byte = status_s;
      end
      oe_d = (phase_q == SCP_PH_DATA) && hdr_q[`SCP_RW_POS];
      sdo_d = rd_byte[3'd7 - bit_q[2:0]];
   end

   always_ff @(negedge sclk or posedge chip_select_n or posedge link_rst) begin
      if (chip_select_n || link_rst) begin
         sdo_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         sdo_q <= sdo_d;
         oe_q <= oe_d;
      end
   end

   assign sdio_out = sdo_q;
   assign sdio_oe = oe_q;
   assign wr_toggle = tog_q;
   assign wr_addr = addr_q;
   assign wr_data = data_q;

endmodule

/* design/scp_top.sv */
`timescale 1ns/1ps
`include "scp_map.svh"
// What this block does
// - with chip select low, one data bit shifts in per rising serial clock.
// - each 24th rising edge in a select period commits the word if it is a write with bits 14:12 zero.
// - a trailing partial word at chip select rise is dropped unwritten.
// - several 24-bit words per select period are each a separate access.
// - a write clears the flag and sends eight data bits on rising edges.
// - a frame with the read flag set never changes any register.
// - read data goes out on the data line, changing on falling edges.
// - global power-down by register or by the active-high pin.
// - apart from srst, which loads 8'h80, power state changes only while the sampling clock is running.
// - per-block power-down; global includes both channels; reference maskable.
// - defaults are differential, external reference, bypass, 2-wire, two's complement.
// - works with no serial access, pins alone steer power and reference.
// - reference select level decodes into four reference and clock options.
// - fourteen-bit result reaches the outputs one clock after sampling.
module scp_top
   import scp_pkg::*;
(
   // system clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // serial link
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   // pins
   input wire logic powerdown_pin,
   input wire logic [1:0] reference_select_pin,
   input wire logic sample_clk_present,
   // converter core samples, two's complement
   input wire logic [13:0] conv_a,
   input wire logic [13:0] conv_b,
   // output words
   output logic [13:0] data_out_a,
   output logic [13:0] data_out_b,
   // power controls
   output logic global_pd,
   output logic pd_adc_a,
   output logic pd_adc_b,
   output logic pd_ref_gain,
   output logic pd_int_ref,
   output logic pd_clk_buf,
   output logic pd_out_drv,
   output logic pd_decim,
   // configuration
   output logic input_single_ended,
   output logic clock_single_ended,
   output logic ref_internal,
   output logic ref_gain_buffer,
   output logic downconverter_en,
   output logic [1:0] iface_mode,
   output logic offset_binary
);

   logic link_rst_q;
   logic wr_toggle;
   logic [11:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] status_q, status_d;
   logic [4:0] pins_s;
   logic pin_s;
   logic [1:0] ref_s;
   logic alive_s;
   logic tog_s;
   logic tog_q;
   logic wr_evt;

   logic [7:0] pdn_q, pdn_d;
   logic [7:0] blk_q, blk_d;
   logic [7:0] cfg_q, cfg_d;
   logic [7:0] pwr_q, pwr_d;
   logic [7:0] target;
   logic pd_req;
   scp_ref_t ref_opt;

   logic [13:0] conv [0:1];
   logic [13:0] dout_q [0:1];
   logic [13:0] dout_d [0:1];
   logic [1:0] chan_pd;

   logic cfg_in_se_q, cfg_clk_se_q, cfg_ref_int_q, cfg_buf_q;
   logic cfg_in_se_d, cfg_clk_se_d, cfg_ref_int_d, cfg_buf_d;

   // reset for the serial side: its clock may be stopped, so it acts asynchronously
   always_ff @(posedge sys_clk) begin
      link_rst_q <= srst;
   end

   scp_link u_link (
      .sclk(sclk),
      .chip_select_n(chip_select_n),
      .sdio_in(sdio_in),
      .sdio_out(sdio_out),
      .sdio_oe(sdio_oe),
      .link_rst(link_rst_q),
      .status_in(status_q),
      .wr_toggle(wr_toggle),
      .wr_addr(wr_addr),
      .wr_data(wr_data)
   );

   scp_sync #(.W(5)) u_pin_sync (
      .clk(sys_clk),
      .d({powerdown_pin, reference_select_pin, sample_clk_present, wr_toggle}),
      .q(pins_s)
   );

   assign pin_s = pins_s[4];
   assign ref_s = pins_s[3:2];
   assign alive_s = pins_s[1];
   assign tog_s = pins_s[0];

   // a toggle change marks a committed word; address and data are held
   // unchanged for at least 24 serial clocks, far longer than the sync delay
   assign wr_evt = tog_s ^ tog_q;

   always_comb begin
      pdn_d = pdn_q;
      blk_d = blk_q;
      cfg_d = cfg_q;
      if (wr_evt) begin
         case (wr_addr)
            `SCP_A_PDN: pdn_d = wr_data;
            `SCP_A_BLK: blk_d = wr_data;
            `SCP_A_CFG: cfg_d = wr_data;
            default: pdn_d = pdn_q;
         endcase
      end
   end

   // all zero after reset is the documented power-up set-up
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         tog_q <= 1'b0;
         pdn_q <= `SCP_RST_BYTE;
         blk_q <= `SCP_RST_BYTE;
         cfg_q <= `SCP_RST_BYTE;
      end else begin
         tog_q <= tog_s;
         pdn_q <= pdn_d;
         blk_q <= blk_d;
         cfg_q <= cfg_d;
      end
   end

   // power-down target from pin and register
   always_comb begin
      pd_req = pin_s | pdn_q[`SCP_PDN_GLOBAL];
      target = 8'h00;
      target[0] = pd_req;
      target[1] = pd_req | blk_q[`SCP_BLK_ADC_A];
      target[2] = pd_req | blk_q[`SCP_BLK_ADC_B];
      // software must only drop the gain amplifier when already powered down
      target[3] = blk_q[`SCP_BLK_REF_GAIN];
      target[4] = blk_q[`SCP_BLK_INT_REF] |
                  (pd_req & pdn_q[`SCP_PDN_REFMASK]);
      target[5] = blk_q[`SCP_BLK_CLK_BUF];
      target[6] = blk_q[`SCP_BLK_OUT_DRV];
      target[7] = blk_q[`SCP_BLK_DECIM] | ~cfg_q[`SCP_CFG_DDC_EN];
   end

   // without a sampling clock the block holds its present power state
   always_comb begin
      pwr_d = pwr_q;
      if (alive_s) begin
         pwr_d = target;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pwr_q <= 8'h80;
      end else begin
         pwr_q <= pwr_d;
      end
   end

   // reference select strap decode
   always_comb begin
      case (ref_s)
         2'b11: ref_opt = SCP_REF_EXT;
         2'b10: ref_opt = SCP_REF_BUF;
         2'b01: ref_opt = SCP_REF_INT;
         2'b00: ref_opt = SCP_REF_INT_SE;
         default: ref_opt = SCP_REF_EXT;
      endcase
   end

   always_comb begin
      cfg_in_se_d = cfg_q[`SCP_CFG_IN_SE];
      cfg_clk_se_d = cfg_q[`SCP_CFG_CLK_SE] | (ref_opt == SCP_REF_INT_SE);
      cfg_ref_int_d = cfg_q[`SCP_CFG_REF_INT] | (ref_opt == SCP_REF_INT) |
                      (ref_opt == SCP_REF_INT_SE);
      cfg_buf_d = (ref_opt == SCP_REF_BUF);
      status_d = {3'b000, ref_s, alive_s, pin_s, pwr_q[0]};
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cfg_in_se_q <= 1'b0;
         cfg_clk_se_q <= 1'b0;
         cfg_ref_int_q <= 1'b0;
         cfg_buf_q <= 1'b0;
         status_q <= 8'h00;
      end else begin
         cfg_in_se_q <= cfg_in_se_d;
         cfg_clk_se_q <= cfg_clk_se_d;
         cfg_ref_int_q <= cfg_ref_int_d;
         cfg_buf_q <= cfg_buf_d;
         status_q <= status_d;
      end
   end

   // output words: one register stage, format flip of the sign bit
   assign conv[0] = conv_a;
   assign conv[1] = conv_b;
   assign chan_pd = pwr_q[2:1];

   genvar c;
   generate
      for (c = 0; c < 2; c++) begin : g_chan
         always_comb begin
            dout_d[c] = 14'h0000;
            if (!chan_pd[c]) begin
               dout_d[c] = conv[c] ^ {cfg_q[`SCP_CFG_OFFS_BIN], 13'h0000};
            end
         end

         always_ff @(posedge sys_clk) begin
            if (srst) begin
               dout_q[c] <= 14'h0000;
            end else begin
               dout_q[c] <= dout_d[c];
            end
         end
      end
   endgenerate

   assign data_out_a = dout_q[0];
   assign data_out_b = dout_q[1];

   assign global_pd = pwr_q[0];
   assign pd_adc_a = pwr_q[1];
   assign pd_adc_b = pwr_q[2];
   assign pd_ref_gain = pwr_q[3];
   assign pd_int_ref = pwr_q[4];
   assign pd_clk_buf = pwr_q[5];
   assign pd_out_drv = pwr_q[6];
   assign pd_decim = pwr_q[7];

   assign input_single_ended = cfg_in_se_q;
   assign clock_single_ended = cfg_clk_se_q;
   assign ref_internal = cfg_ref_int_q;
   assign ref_gain_buffer = cfg_buf_q;
   assign downconverter_en = cfg_q[`SCP_CFG_DDC_EN];
   assign iface_mode = cfg_q[`SCP_CFG_IF_HI:`SCP_CFG_IF_LO];
   assign offset_binary = cfg_q[`SCP_CFG_OFFS_BIN];

endmodule

/* verification/scp_host_model.sv */
`timescale 1ns/1ps
module scp_host_model (
   // serial link
   output logic sclk,
   output logic chip_select_n,
   output logic sdio_in,
   input wire logic sdio_out,
   input wire logic sdio_oe
);
   logic drv;
   // the shared line: the device wins while it drives
   assign sdio_in = sdio_oe ? sdio_out : drv;
   // one clean rise of chip select so the frame counters start cleared
   initial begin
      sclk = 1'b0;
      chip_select_n = 1'b0;
      drv = 1'b0;
      #1;
      chip_select_n = 1'b1;
   end
   // clock stands low between frames; a released line shows the inverse of its last bit
   task automatic frame(input logic [47:0] w, input int n, output logic [7:0] rd);
      int b;
      #3;
      chip_select_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         b = i % 24;
         if (w[47 - (i / 24) * 24] && b >= 16) drv = ~drv;
         else drv = w[47 - i];
         #24;
         sclk = 1'b1;
         if (b >= 16) rd = {rd[6:0], sdio_in};
         #24;
         sclk = 1'b0;
      end
      #24;
      chip_select_n = 1'b1;
      drv = ~drv;
      #40;
   endtask
endmodule

/* verification/scp_top_assertions.sv */
`timescale 1ns/1ps
module scp_top_assertions (
   // clocks and resets
   input wire logic sys_clk,
   input wire logic srst,
   // serial link
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic sdio_in,
   input wire logic sdio_oe,
   // pins and samples
   input wire logic powerdown_pin,
   input wire logic [1:0] reference_select_pin,
   input wire logic sample_clk_present,
   input wire logic [13:0] conv_a,
   input wire logic [13:0] data_out_a,
   input wire logic offset_binary,
   // power and reference
   input wire logic global_pd,
   input wire logic pd_adc_a,
   input wire logic pd_adc_b,
   input wire logic ref_internal,
   input wire logic clock_single_ended
);
   logic [4:0] cnt_q, cnt_d;
   logic rw_q, rw_d;
   // frame position seen from outside; chip select high restarts it
   always_comb begin
      cnt_d = (cnt_q == 5'h17) ? 5'h00 : cnt_q + 5'h01;
      rw_d = (cnt_q == 5'h00) ? sdio_in : rw_q;
   end
   always_ff @(posedge sclk or posedge chip_select_n) begin
      if (chip_select_n) begin
         cnt_q <= 5'h00;
         rw_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         rw_q <= rw_d;
      end
   end
   sequence no_clk4;
      !sample_clk_present [*4];
   endsequence
   sequence pin_req6;
      (powerdown_pin && sample_clk_present) [*6];
   endsequence
   a_oe_released: assert property (@(posedge sys_clk) chip_select_n |-> !sdio_oe)
      else $error("data line driven without chip select");
   a_oe_window: assert property (@(posedge sclk) disable iff (chip_select_n)
      sdio_oe == (rw_q && cnt_q >= 5'h10)) else $error("read drive window wrong");
   a_data_follow: assert property (@(posedge sys_clk) disable iff (srst)
      (!$past(srst) && !pd_adc_a && !$past(pd_adc_a)) |->
      data_out_a == ($past(conv_a) ^ {$past(offset_binary), 13'h0000}))
      else $error("output word not one cycle behind sample");
   a_data_zero: assert property (@(posedge sys_clk) disable iff (srst)
      (pd_adc_a && $past(pd_adc_a)) |-> data_out_a == 14'h0000)
      else $error("powered down channel not zero");
   a_global_chans: assert property (@(posedge sys_clk) disable iff (srst)
      global_pd |-> pd_adc_a && pd_adc_b) else $error("global power-down missed a channel");
   a_frozen_noclk: assert property (@(posedge sys_clk) disable iff (srst)
      no_clk4 |=> $stable(global_pd) && $stable(pd_adc_a))
      else $error("power state changed without sampling clock");
   a_pin_pd: assert property (@(posedge sys_clk) disable iff (srst)
      pin_req6 |-> global_pd) else $error("pin power-down not taken");
   a_strap_se: assert property (@(posedge sys_clk) disable iff (srst)
      (reference_select_pin == 2'h0) [*6] |-> ref_internal && clock_single_ended)
      else $error("low strap level not decoded");
endmodule
bind scp_top scp_top_assertions scp_top_assertions_inst (.sys_clk, .srst, .sclk,
   .chip_select_n, .sdio_in, .sdio_oe, .powerdown_pin, .reference_select_pin,
   .sample_clk_present, .conv_a, .data_out_a, .global_pd, .pd_adc_a, .pd_adc_b,
   .ref_internal, .clock_single_ended, .offset_binary);

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic sclk, chip_select_n, sdio_in, sdio_out, sdio_oe;
   logic powerdown_pin = 1'b0;
   logic [1:0] reference_select_pin = 2'h3;
   logic sample_clk_present = 1'b1;
   logic [13:0] conv_a = 14'h0000;
   logic [13:0] conv_b = 14'h0000;
   logic [13:0] data_out_a, data_out_b, ea, eb;
   logic global_pd, pd_adc_a, pd_adc_b, pd_ref_gain, pd_int_ref, pd_clk_buf, pd_out_drv;
   logic pd_decim, input_single_ended, clock_single_ended, ref_internal, ref_gain_buffer;
   logic downconverter_en, offset_binary;
   logic [1:0] iface_mode;
   logic [7:0] rdv;
   logic [31:0] seed = 32'h0000A909;
   int miscompares = 0;
   int checks_done = 0;
   int mdl[4];
   always #10 sys_clk = ~sys_clk;
   scp_top scp_top_inst (.sys_clk, .srst, .sclk, .chip_select_n, .sdio_in, .sdio_out,
      .sdio_oe, .powerdown_pin, .reference_select_pin, .sample_clk_present, .conv_a,
      .conv_b, .data_out_a, .data_out_b, .global_pd, .pd_adc_a, .pd_adc_b, .pd_ref_gain,
      .pd_int_ref, .pd_clk_buf, .pd_out_drv, .pd_decim, .input_single_ended,
      .clock_single_ended, .ref_internal, .ref_gain_buffer, .downconverter_en,
      .iface_mode, .offset_binary);
   scp_host_model host_inst (.sclk, .chip_select_n, .sdio_in, .sdio_out, .sdio_oe);
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_out(input string nm, input logic [13:0] e, input logic [13:0] g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic print_verdict();
      if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // a read sends no data of its own; the host releases the line then
   task automatic acc(input logic rw, input logic [11:0] a, input logic [7:0] d);
      host_inst.frame({rw, 3'b000, a, d, 24'h000000}, 24, rdv);
      if (!rw && a >= 12'h0C0 && a <= 12'h0C3) mdl[a - 12'h0C0] = d;
      @(negedge sys_clk);
   endtask
   task automatic rd_chk(input logic [11:0] a);
      logic [7:0] e;
      e = (a >= 12'h0C0 && a <= 12'h0C3) ? 8'(mdl[a - 12'h0C0]) : 8'h00;
      acc(1'b1, a, 8'h00);
      chk_reg("readback", e, rdv);
   endtask
   task automatic settle();
      repeat (12) @(negedge sys_clk);
   endtask
   initial begin
      #1000000;
      miscompares++;
      print_verdict();
   end
   initial begin
      repeat (8) @(negedge sys_clk);
      srst = 1'b0;
      repeat (3) @(negedge sys_clk);
      for (int a = 0; a < 4; a++) rd_chk(12'h0C0 + 12'(a));
      chk_out("defaults", 14'h0100, {5'h00, pd_decim, input_single_ended, clock_single_ended,
         ref_internal, downconverter_en, iface_mode, offset_binary, global_pd});
      acc(1'b1, 12'h0C4, 8'h00);
      chk_reg("status", 8'h1C, rdv);
      for (int i = 0; i < 6; i++) begin
         acc(1'b0, 12'h0C2 + 12'(i % 2), 8'(xs()) & 8'h7F);
         rd_chk(12'h0C2 + 12'(i % 2));
      end
      settle();
      chk_out("config", 14'(mdl[2]), {7'h00, offset_binary, iface_mode, downconverter_en,
         ref_internal, clock_single_ended, input_single_ended});
      host_inst.frame({4'h0, 12'h0C3, 8'h5A, 24'h000000}, 23, rdv);
      rd_chk(12'h0C3);
      host_inst.frame({4'h0, 12'h0C3, 8'hA5, 4'h8, 12'h0C3, 8'h00}, 48, rdv);
      mdl[3] = 8'hA5;
      chk_reg("back_to_back", 8'hA5, rdv);
      host_inst.frame({4'h1, 12'h0C3, 8'h3C, 24'h000000}, 24, rdv);
      rd_chk(12'h0C3);
      rd_chk(12'h0A5);
      acc(1'b0, 12'h0C2, 8'h00);
      for (int c = 0; c < 4; c++) begin
         reference_select_pin = 2'(c);
         settle();
         chk_out("strap", {11'h000, c < 2, c == 0, c == 2},
            {11'h000, ref_internal, clock_single_ended, ref_gain_buffer});
      end
      reference_select_pin = 2'h3;
      powerdown_pin = 1'b1;
      settle();
      chk_out("pin_pd", 14'h0007, {11'h000, global_pd, pd_adc_a, pd_adc_b});
      powerdown_pin = 1'b0;
      sample_clk_present = 1'b0;
      acc(1'b0, 12'h0C0, 8'h03);
      settle();
      chk_out("frozen", 14'h0007, {11'h000, global_pd, pd_adc_a, pd_adc_b});
      sample_clk_present = 1'b1;
      settle();
      chk_out("reg_pd", 14'h0007, {11'h000, global_pd, pd_adc_a, pd_int_ref});
      acc(1'b0, 12'h0C1, 8'h04);
      acc(1'b0, 12'h0C0, 8'h01);
      settle();
      chk_out("ref_mask", 14'h000E,
         {10'h000, pd_ref_gain, global_pd, pd_adc_a, pd_int_ref});
      acc(1'b0, 12'h0C1, 8'h30);
      acc(1'b0, 12'h0C0, 8'h00);
      settle();
      chk_out("blocks", 14'h0007,
         {10'h000, pd_ref_gain, pd_decim, pd_clk_buf, pd_out_drv});
      for (int i = 0; i < 20; i++) begin
         @(negedge sys_clk);
         if (i > 0) chk_out("data_a", ea, data_out_a);
         if (i > 0) chk_out("data_b", eb, data_out_b);
         ea = 14'(xs());
         eb = 14'(xs());
         conv_a = ea;
         conv_b = eb;
      end
      print_verdict();
   end
endmodule
